// ### verilog/threshold_interrupt_config.sv
// Purpose: limit registers, limit checks and interrupt signalling
// Assumes: results and conv_done come from logic on clk
// Notes: registers reached over the two-wire slave port
`timescale 1ns/1ps
`default_nettype none
module threshold_interrupt_config
  import limit_irq_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic int_in,
  output logic int_out,
  output logic int_oe_n,
  input wire conv_result_t conv_result,
  input wire logic conv_done,
  input wire sensor_mode_t sensor_mode,
  output logic temp_channel_enable,
  output logic conv_trigger,
  output logic wake_request
);
  `include "limit_irq_cfg.svh"

  // Pin synchronisers; bit 0 feeds only bit 1
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic [1:0] int_sync_reg;
  // Delayed copies for edge detection
  logic scl_d_reg;
  logic sda_d_reg;
  logic int_d_reg;
  // Detected bus events
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // Slave state
  bus_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] ptr_reg;
  logic first_reg;
  logic rw_reg;
  logic nack_reg;
  logic busy_reg;
  logic addressed_reg;
  logic wr_en_reg;
  logic [7:0] wr_addr_reg;
  logic [7:0] wr_data_reg;
  logic [7:0] rd_data;

  // Register file
  logic [7:0] x_limit_reg;
  logic [7:0] y_limit_reg;
  logic [7:0] z_limit_reg;
  logic [7:0] temp_limit_reg;
  irq_setup_t setup_reg;

  // Limit check results
  logic [7:0] axis_code [3];
  logic [2:0] axis_range;
  logic [2:0] axis_hit;
  logic [6:0] temp_code;
  logic [15:0] temp_thr;
  logic temp_hit;
  logic any_hit;

  // Interrupt state
  logic [1:0] cross_cnt_reg;
  logic limit_event;
  logic set_pend;
  logic pend_reg;
  logic route_ok;
  logic bus_aware;
  logic allowed;
  logic pulse_start;
  logic pulse_busy;
  logic irq_on;
  logic int_fall;
  logic scl_out_reg;
  logic sda_out_reg;
  logic int_out_reg;
  logic scl_oe_n_reg;
  logic sda_oe_n_reg;
  logic int_oe_n_reg;
  logic conv_trigger_reg;
  logic wake_request_reg;

  // Two-stage sync of every pin, plus one delay stage for edges
  always_ff @(posedge clk) begin
    if (!rstn) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      int_sync_reg <= 2'h3;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      int_d_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      int_sync_reg <= {int_sync_reg[0], int_in};
      scl_d_reg <= scl_sync_reg[1];
      sda_d_reg <= sda_sync_reg[1];
      int_d_reg <= int_sync_reg[1];
    end
  end

  // Edges and start/stop conditions, all from the second stage on
  assign scl_rise = scl_sync_reg[1] & ~scl_d_reg;
  assign scl_fall = ~scl_sync_reg[1] & scl_d_reg;
  assign start_det = scl_sync_reg[1] & scl_d_reg & sda_d_reg & ~sda_sync_reg[1];
  assign stop_det = scl_sync_reg[1] & scl_d_reg & ~sda_d_reg & sda_sync_reg[1];

  // Read mux; unmapped pointers read zero
  always_comb begin
    case (ptr_reg)
      `OFS_X_LIMIT: rd_data = x_limit_reg;
      `OFS_Y_LIMIT: rd_data = y_limit_reg;
      `OFS_Z_LIMIT: rd_data = z_limit_reg;
      `OFS_TEMP_LIMIT: rd_data = temp_limit_reg;
      `OFS_IRQ_SETUP: rd_data = setup_reg;
      default: rd_data = 8'h00;
    endcase
  end

  // Two-wire slave: address, pointer byte, then auto-incrementing data
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      first_reg <= 1'b0;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      busy_reg <= 1'b0;
      addressed_reg <= 1'b0;
      wr_en_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
    end else begin
      addressed_reg <= 1'b0;
      wr_en_reg <= 1'b0;
      if (start_det) begin
        // Start or repeated start: bus busy until stop
        state_reg <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        first_reg <= 1'b1;
        busy_reg <= 1'b1;
      end else if (stop_det) begin
        state_reg <= ST_IDLE;
        busy_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_ADDR: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == 4'h8) begin
              // Foreign address: sit out until the next start or stop
              if (shift_reg[7:1] == `DEV_ADDR) begin
                state_reg <= ST_ACK;
                rw_reg <= shift_reg[0];
                addressed_reg <= 1'b1;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_ACK: begin
            if (scl_rise) begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == 4'h9) begin
              bit_cnt_reg <= 4'h0;
              if (rw_reg) begin
                shift_reg <= rd_data;
                ptr_reg <= ptr_reg + 8'h01;
                state_reg <= ST_READ;
              end else begin
                state_reg <= ST_WRITE;
              end
            end
          end
          ST_WRITE: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == 4'h8) begin
              // First byte sets the pointer, later bytes are data
              if (first_reg) begin
                ptr_reg <= shift_reg;
                first_reg <= 1'b0;
              end else begin
                wr_en_reg <= 1'b1;
                wr_addr_reg <= ptr_reg;
                wr_data_reg <= shift_reg;
                ptr_reg <= ptr_reg + 8'h01;
              end
              state_reg <= ST_ACK;
            end
          end
          ST_READ: begin
            if (scl_rise) begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt_reg == 4'h8) begin
                state_reg <= ST_RACK;
              end else begin
                shift_reg <= {shift_reg[6:0], 1'b0};
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              nack_reg <= sda_sync_reg[1];
            end else if (scl_fall && bit_cnt_reg == 4'h9) begin
              // Controller nack ends the read
              if (nack_reg) begin
                state_reg <= ST_IDLE;
              end else begin
                bit_cnt_reg <= 4'h0;
                shift_reg <= rd_data;
                ptr_reg <= ptr_reg + 8'h01;
                state_reg <= ST_READ;
              end
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Register writes; the reserved setup bit always reads zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      x_limit_reg <= `REG_RESET;
      y_limit_reg <= `REG_RESET;
      z_limit_reg <= `REG_RESET;
      temp_limit_reg <= `REG_RESET;
      setup_reg <= `REG_RESET;
    end else if (wr_en_reg) begin
      case (wr_addr_reg)
        `OFS_X_LIMIT: x_limit_reg <= wr_data_reg;
        `OFS_Y_LIMIT: y_limit_reg <= wr_data_reg;
        `OFS_Z_LIMIT: z_limit_reg <= wr_data_reg;
        `OFS_TEMP_LIMIT: temp_limit_reg <= wr_data_reg;
        `OFS_IRQ_SETUP: begin
          setup_reg <= wr_data_reg;
          setup_reg.rsvd <= 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  // Channel enable straight from its register bit
  assign temp_channel_enable = temp_limit_reg[`TEMP_EN_BIT];

  // Per-axis comparison; X and Y share the planar range
  assign axis_code[0] = x_limit_reg;
  assign axis_code[1] = y_limit_reg;
  assign axis_code[2] = z_limit_reg;
  assign axis_range = {sensor_mode.vertical_range, {2{sensor_mode.planar_range}}};
  for (genvar i = 0; i < 3; i++) begin : g_axis
    limit_compare i_limit_compare (
      .limit_code(axis_code[i]),
      .range_sel(axis_range[i]),
      .below_sel(sensor_mode.below_limit),
      .result(conv_result.axis[i]),
      .crossed(axis_hit[i])
    );
  end

  // Temperature check only above the limit and only with the channel on
  assign temp_code = temp_limit_reg[7:1];
  assign temp_thr = 16'({9'h000, temp_code} * 16'(`TEMP_STEP_DEG)) - 16'(`TEMP_OFFSET_DEG);
  assign temp_hit = temp_channel_enable && (|temp_code) &&
                    ($signed(conv_result.temp) > $signed(temp_thr));
  assign any_hit = (|axis_hit) | temp_hit;

  // Crossing counter: one or four crossings per limit event
  assign limit_event = conv_done && any_hit &&
                       (!sensor_mode.crossing_four || cross_cnt_reg == `CROSS_LAST);
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cross_cnt_reg <= 2'h0;
    end else if (conv_done && any_hit) begin
      cross_cnt_reg <= limit_event ? 2'h0 : cross_cnt_reg + 2'h1;
    end
  end

  // Route decode; reserved codes behave as no interrupt
  assign route_ok = (setup_reg.route != `ROUTE_NONE) && (setup_reg.route <= `ROUTE_SCL_AWARE);
  assign bus_aware = (setup_reg.route == `ROUTE_PIN_AWARE) ||
                     (setup_reg.route == `ROUTE_SCL_AWARE);
  assign allowed = route_ok && !(bus_aware && busy_reg);

  // Event sources gated by their enables
  assign set_pend = (conv_done && setup_reg.result_en) ||
                    (limit_event && setup_reg.limit_en);
  assign pulse_start = setup_reg.pulse_sel && pend_reg && allowed && !pulse_busy;

  // Pending flag; a new event beats the clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pend_reg <= 1'b0;
    end else if (set_pend) begin
      pend_reg <= 1'b1;
    end else if (setup_reg.pulse_sel ? pulse_start : addressed_reg) begin
      pend_reg <= 1'b0;
    end
  end

  // Pulse timer for the pulsed setting
  irq_pulse_timer i_irq_pulse_timer (
    .clk(clk),
    .rstn(rstn),
    .start(pulse_start),
    .busy(pulse_busy)
  );

  assign irq_on = allowed && (setup_reg.pulse_sel ? pulse_busy : pend_reg);
  // Own drive excluded, or an asserted interrupt would retrigger us
  assign int_fall = int_d_reg & ~int_sync_reg[1] & int_oe_n_reg;

  // Registered pin drivers; all open drain, low when enabled
  always_ff @(posedge clk) begin
    if (!rstn) begin
      scl_out_reg <= 1'b0;
      sda_out_reg <= 1'b0;
      int_out_reg <= 1'b0;
      scl_oe_n_reg <= 1'b1;
      sda_oe_n_reg <= 1'b1;
      int_oe_n_reg <= 1'b1;
    end else begin
      scl_out_reg <= 1'b0;
      sda_out_reg <= 1'b0;
      int_out_reg <= 1'b0;
      sda_oe_n_reg <= !((state_reg == ST_ACK) || (state_reg == ST_READ && !shift_reg[7]));
      int_oe_n_reg <= !(irq_on && (setup_reg.route == `ROUTE_PIN ||
                                   setup_reg.route == `ROUTE_PIN_AWARE));
      scl_oe_n_reg <= !(irq_on && (setup_reg.route == `ROUTE_SCL ||
                                   setup_reg.route == `ROUTE_SCL_AWARE));
    end
  end

  // Pin falling edge: wake and optional conversion start unless masked
  always_ff @(posedge clk) begin
    if (!rstn) begin
      conv_trigger_reg <= 1'b0;
      wake_request_reg <= 1'b0;
    end else begin
      conv_trigger_reg <= int_fall && !setup_reg.pin_mask && sensor_mode.pin_trigger;
      wake_request_reg <= int_fall && !setup_reg.pin_mask;
    end
  end

  assign scl_out = scl_out_reg;
  assign sda_out = sda_out_reg;
  assign int_out = int_out_reg;
  assign scl_oe_n = scl_oe_n_reg;
  assign sda_oe_n = sda_oe_n_reg;
  assign int_oe_n = int_oe_n_reg;
  assign conv_trigger = conv_trigger_reg;
  assign wake_request = wake_request_reg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Helper: length of the current pulse
  logic [`IRQ_PULSE_W:0] pulse_len_reg;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pulse_len_reg <= '0;
    end else begin
      pulse_len_reg <= pulse_busy ? pulse_len_reg + 1'b1 : '0;
    end
  end

  AST_ZERO_X: assert property ((x_limit_reg == 8'h00) |-> !axis_hit[0])
    else $error("x hit with zero code");
  AST_ZERO_Y: assert property ((y_limit_reg == 8'h00) |-> !axis_hit[1])
    else $error("y hit with zero code");
  AST_ZERO_Z: assert property ((z_limit_reg == 8'h00) |-> !axis_hit[2])
    else $error("z hit with zero code");
  AST_TEMP_ZERO: assert property ((temp_code == 7'h00 || !temp_channel_enable) |-> !temp_hit)
    else $error("temperature hit while disabled");
  AST_RESULT_IRQ: assert property (conv_done && setup_reg.result_en |=> pend_reg)
    else $error("completion did not set pending");
  AST_NO_SOURCE: assert property (!pend_reg && !(conv_done && setup_reg.result_en) &&
                                  !(limit_event && setup_reg.limit_en) |=> !pend_reg)
    else $error("pending set without enabled source");
  AST_ONE_CROSS: assert property (conv_done && any_hit && !sensor_mode.crossing_four &&
                                  setup_reg.limit_en |=> pend_reg)
    else $error("single crossing did not set pending");
  AST_PULSE_LEN: assert property ($fell(pulse_busy) |-> pulse_len_reg == `IRQ_PULSE_CYC)
    else $error("pulse length wrong");
  AST_ROUTE_OFF: assert property ((setup_reg.route == `ROUTE_NONE) ##1
                                  (setup_reg.route == `ROUTE_NONE) |-> int_oe_n && scl_oe_n)
    else $error("interrupt driven with no route");
  AST_BUSY_HOLD: assert property ($past(busy_reg && bus_aware) |-> int_oe_n && scl_oe_n)
    else $error("interrupt driven during bus activity");
  AST_MASK_TRIG: assert property ($past(setup_reg.pin_mask) |-> !conv_trigger && !wake_request)
    else $error("masked pin caused trigger");

  COV_PULSE: cover property ($rose(pulse_busy));
  COV_LATCH_CLEAR: cover property (pend_reg && addressed_reg && !setup_reg.pulse_sel);
  COV_TRIGGER: cover property (conv_trigger);
  COV_FOUR: cover property (limit_event && sensor_mode.crossing_four);
endmodule
`default_nettype wire

// ### pkg/limit_irq_cfg.svh
// Purpose: constants for the limit check and interrupt signalling block
// Assumes: 40 MHz system clock, two-wire register port
// Notes: offsets are the register pointer values seen on the bus
//
// Summary of operation
// - X limit is signed 8-bit code
// - Y limit is signed 8-bit code
// - Z limit is signed 8-bit code
// - X/Y step is range/128, doubles with range
// - Z step is range/128, doubles with range
// - Zero X/Y code disables that comparison
// - Zero Z code disables that comparison
// - Temperature code bits 7:1, 8 C steps
// - Zero temperature code disables temperature check
// - Bit 0 enables temperature channel acquisition
// - Bit 7 enables interrupt on conversion complete
// - Bit 6 enables interrupt on limit crossing
// - Bit 5 chooses latched or 10 us pulse
// - Bits 4:2 choose route: none, pin, SCL
// - Bus-aware routes wait for a free bus
// - Pin mask ignores pin for wake, trigger
// - Limit interrupt after one or four crossings
// - Direction select: above or below limit
// - Pin edge starts conversion when selected
`ifndef LIMIT_IRQ_CFG_SVH
`define LIMIT_IRQ_CFG_SVH

// Register pointer values
`define OFS_X_LIMIT 8'h04
`define OFS_Y_LIMIT 8'h05
`define OFS_Z_LIMIT 8'h06
`define OFS_TEMP_LIMIT 8'h07
`define OFS_IRQ_SETUP 8'h08
`define REG_RESET 8'h00

// Bus address of this device
`define DEV_ADDR 7'h22

// Field positions: reserved bit of the setup register, channel enable bit of the temperature limit register
`define SETUP_RSVD_BIT 1
`define TEMP_EN_BIT 0

// Route encodings
`define ROUTE_NONE 3'h0
`define ROUTE_PIN 3'h1
`define ROUTE_PIN_AWARE 3'h2
`define ROUTE_SCL 3'h3
`define ROUTE_SCL_AWARE 3'h4

// Timing
`define CLK_PERIOD_NS 25
`define IRQ_PULSE_US 10
`define IRQ_PULSE_CYC ((`IRQ_PULSE_US * 1000) / `CLK_PERIOD_NS)
`define IRQ_PULSE_W 9

// Crossing count for the four-crossing setting, minus one
`define CROSS_LAST 2'h3

// Temperature code scaling, anchored at code 1A = -41 C
`define TEMP_STEP_DEG 8
`define TEMP_ANCHOR_CODE 26
`define TEMP_ANCHOR_DEG (-41)
`define TEMP_OFFSET_DEG ((`TEMP_ANCHOR_CODE * `TEMP_STEP_DEG) - `TEMP_ANCHOR_DEG)

`endif

// ### pkg/limit_irq_pkg.sv
// Purpose: shared types of the limit check and interrupt block
// Assumes: constants live in limit_irq_cfg.svh
// Notes: none
package limit_irq_pkg;
  // Interrupt setup register layout, bit 7 first
  typedef struct packed {
    logic result_en;
    logic limit_en;
    logic pulse_sel;
    logic [2:0] route;
    logic rsvd;
    logic pin_mask;
  } irq_setup_t;

  // Results from the conversion core: X, Y, Z then temperature in C
  typedef struct packed {
    logic [2:0][15:0] axis;
    logic [15:0] temp;
  } conv_result_t;

  // Configuration bits held outside this block
  typedef struct packed {
    logic planar_range;
    logic vertical_range;
    logic crossing_four;
    logic below_limit;
    logic pin_trigger;
  } sensor_mode_t;

  // Two-wire slave states
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK, ST_WRITE, ST_READ, ST_RACK
  } bus_state_t;
endpackage

// ### verilog/limit_compare.sv
// Purpose: one axis limit comparison
// Assumes: result is signed, full scale spans the selected range
// Notes: combinational
`timescale 1ns/1ps
`default_nettype none
module limit_compare
  import limit_irq_pkg::*;
(
  input wire logic [7:0] limit_code,
  input wire logic range_sel,
  input wire logic below_sel,
  input wire logic [15:0] result,
  output logic crossed
);
  // Field and limit in a common unit: range doubling scales both
  logic signed [17:0] field;
  logic signed [17:0] limit;

  // Field scaled by the range setting
  assign field = range_sel ? {result[15], result, 1'b0} : {{2{result[15]}}, result};
  // Code step is 1/128 of full scale, twice as heavy on the wide range
  assign limit = range_sel ? {limit_code[7], limit_code, 9'h000} :
                 {{2{limit_code[7]}}, limit_code, 8'h00};

  // Zero code means no comparison at all; direction picks above or below
  assign crossed = (|limit_code) &&
                   (below_sel ? (field < limit) : (field > limit));
endmodule
`default_nettype wire

// ### verilog/irq_pulse_timer.sv
// Purpose: fixed-length interrupt pulse
// Assumes: start is ignored while a pulse runs
// Notes: length set by IRQ_PULSE_CYC
`timescale 1ns/1ps
`default_nettype none
module irq_pulse_timer
  import limit_irq_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  output logic busy
);
  `include "limit_irq_cfg.svh"
  // Remaining pulse cycles
  logic [`IRQ_PULSE_W-1:0] cnt_reg;

  // Load on start, count down to zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_reg <= '0;
    end else if (start && cnt_reg == '0) begin
      cnt_reg <= `IRQ_PULSE_W'(`IRQ_PULSE_CYC);
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - `IRQ_PULSE_W'(1);
    end
  end

  assign busy = (cnt_reg != '0);
endmodule
`default_nettype wire

// ### bench/bus_ctrl_model.sv
// Purpose: two-wire bus controller model for the register port
// Assumes: open-drain wires with pull-ups, SCL period 200 ns
// Notes: no clock stretching, so never address the device while it holds SCL
`timescale 1ns/1ps
`default_nettype none
module bus_ctrl_model (
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low
);
  logic all_ack; // Every device ack seen so far
  // Released lines float high through the pull-ups
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    all_ack = 1'b1;
  end
  // Quarter period; the gap keeps SDA moves clear of the synced SCL fall
  task automatic hp;
    repeat (2) @(posedge clk);
    #2;
  endtask
  // Start or repeated start: SDA falls while SCL is high
  task automatic start;
    hp;
    sda_low = 1'b0;
    hp;
    scl_low = 1'b0;
    hp;
    sda_low = 1'b1;
    hp;
    scl_low = 1'b1;
  endtask
  // Stop: SDA rises while SCL is high
  task automatic stop;
    hp;
    sda_low = 1'b1;
    hp;
    scl_low = 1'b0;
    hp;
    sda_low = 1'b0;
  endtask
  // One bit, sampled at the end of the high phase
  task automatic bit_x(input logic b, output logic s);
    hp;
    sda_low = !b;
    hp;
    scl_low = 1'b0;
    hp;
    hp;
    s = sda;
    scl_low = 1'b1;
  endtask
  // Byte MSB first, then the ninth bit with SDA released
  task automatic byte_x(input logic [7:0] d, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(1'b1, a);
  endtask
  // Register write: address, pointer, data
  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    logic [7:0] q;
    logic a;
    start;
    byte_x(8'h44, q, a);
    all_ack &= !a;
    byte_x(p, q, a);
    all_ack &= !a;
    byte_x(v, q, a);
    all_ack &= !a;
    stop;
  endtask
  // Register read: pointer write, repeated start, one byte then nack
  task automatic rd(input logic [7:0] p, output logic [7:0] v);
    logic [7:0] q;
    logic a;
    start;
    byte_x(8'h44, q, a);
    all_ack &= !a;
    byte_x(p, q, a);
    all_ack &= !a;
    start;
    byte_x(8'h45, q, a);
    all_ack &= !a;
    byte_x(8'hFF, v, a);
    stop;
  endtask
endmodule
`default_nettype wire

// ### bench/tb_threshold_interrupt_config.sv
// Purpose: self-checking bench for limit checks and interrupt signalling
// Assumes: latched clear on address match, pulse of 400 clocks
// Notes: reset values first, then event rows, pulse, count, bus and pin cases
`timescale 1ns/1ps
`default_nettype none
module tb_threshold_interrupt_config;
  import limit_irq_pkg::*;
  typedef struct packed {
    logic [7:0] setup;
    logic [1:0] axis;
    logic [7:0] lim;
    logic [15:0] val;
    logic [4:0] mode;
    logic ei;
    logic es;
  } row_t;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic conv_done = 1'b0;
  logic tb_int_low = 1'b0;
  logic scl, sda, int_pin, m_scl_low, m_sda_low;
  logic scl_out, scl_oe_n, sda_out, sda_oe_n, int_out, int_oe_n;
  logic temp_channel_enable, conv_trigger, wake_request;
  logic [7:0] d;
  conv_result_t cr = '0;
  sensor_mode_t mode = '0;
  int miscompares = 0;
  int checked = 0;
  int wakes = 0;
  int trigs = 0;
  row_t rows[18] = '{
    '{8'h84, 2'd0, 8'h00, 16'h0000, 5'h00, 1'b1, 1'b0},
    '{8'h04, 2'd0, 8'h00, 16'h0000, 5'h00, 1'b0, 1'b0},
    '{8'h44, 2'd0, 8'h10, 16'h1001, 5'h00, 1'b1, 1'b0},
    '{8'h44, 2'd0, 8'h10, 16'h1000, 5'h00, 1'b0, 1'b0},
    '{8'h04, 2'd0, 8'h10, 16'h1100, 5'h00, 1'b0, 1'b0},
    '{8'h44, 2'd1, 8'hF0, 16'hEFFF, 5'h02, 1'b1, 1'b0},
    '{8'h44, 2'd1, 8'hF0, 16'hF000, 5'h02, 1'b0, 1'b0},
    '{8'h44, 2'd2, 8'h00, 16'h7FFF, 5'h00, 1'b0, 1'b0},
    '{8'h44, 2'd2, 8'h7F, 16'h7FFF, 5'h08, 1'b1, 1'b0},
    '{8'h44, 2'd0, 8'h00, 16'h7FFF, 5'h10, 1'b0, 1'b0},
    '{8'h44, 2'd3, 8'h35, 16'hFFD8, 5'h00, 1'b1, 1'b0},
    '{8'h44, 2'd3, 8'h35, 16'hFFD7, 5'h00, 1'b0, 1'b0},
    '{8'h44, 2'd3, 8'h01, 16'h7FFF, 5'h00, 1'b0, 1'b0},
    '{8'h8C, 2'd0, 8'h00, 16'h0000, 5'h00, 1'b0, 1'b1},
    '{8'h90, 2'd0, 8'h00, 16'h0000, 5'h00, 1'b0, 1'b1},
    '{8'h80, 2'd0, 8'h00, 16'h0000, 5'h00, 1'b0, 1'b0},
    '{8'h9E, 2'd0, 8'h00, 16'h0000, 5'h00, 1'b0, 1'b0},
    '{8'h88, 2'd0, 8'h00, 16'h0000, 5'h00, 1'b1, 1'b0}
  };
  // Open-drain wires: low if any party pulls
  assign scl = !(m_scl_low || (!scl_oe_n && !scl_out));
  assign sda = !(m_sda_low || (!sda_oe_n && !sda_out));
  assign int_pin = !(tb_int_low || (!int_oe_n && !int_out));
  always #12.5 clk = ~clk;
  // Pulses last one cycle, so count them as they pass
  always @(posedge clk) begin
    if (wake_request === 1'b1) wakes++;
    if (conv_trigger === 1'b1) trigs++;
  end
  bus_ctrl_model i_bus_ctrl_model (.clk(clk), .scl(scl), .sda(sda), .scl_low(m_scl_low),
    .sda_low(m_sda_low));
  threshold_interrupt_config i_threshold_interrupt_config (.clk(clk), .rstn(rstn),
    .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .int_in(int_pin), .int_out(int_out), .int_oe_n(int_oe_n),
    .conv_result(cr), .conv_done(conv_done), .sensor_mode(mode),
    .temp_channel_enable(temp_channel_enable), .conv_trigger(conv_trigger),
    .wake_request(wake_request));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Reset for two cycles, then the settle gap before the first start
  task automatic rst;
    @(posedge clk);
    #2 rstn = 1'b0;
    repeat (2) @(posedge clk);
    #2 rstn = 1'b1;
    repeat (4) @(posedge clk);
    #2;
  endtask
  // One completion pulse, then the wait until the pin can move
  task automatic done_pulse;
    @(posedge clk);
    #2 conv_done = 1'b1;
    @(posedge clk);
    #2 conv_done = 1'b0;
    repeat (3) @(posedge clk);
    #2;
  endtask
  // Outside party pulls the interrupt pin low for a while
  task automatic pin_pulse;
    @(posedge clk);
    #2 tb_int_low = 1'b1;
    repeat (10) @(posedge clk);
    #2 tb_int_low = 1'b0;
    repeat (10) @(posedge clk);
  endtask
  initial begin
    #2_000_000;
    miscompares++;
    tally_and_finish;
  end
  initial begin
    rst;
    check({int_oe_n, scl_oe_n, sda_oe_n}, 16'h0007);
    // Limit, temperature and setup reset to zero; unmapped pointer reads zero
    for (int a = 4; a < 10; a++) begin
      i_bus_ctrl_model.rd(a[7:0], d);
      check(d, 16'h0000);
    end
    foreach (rows[i]) begin
      rst;
      mode = sensor_mode_t'(rows[i].mode);
      cr = '0;
      if (rows[i].axis == 2'd3) cr.temp = rows[i].val;
      else cr.axis[rows[i].axis] = rows[i].val;
      i_bus_ctrl_model.wr(8'h04 + {6'h00, rows[i].axis}, rows[i].lim);
      i_bus_ctrl_model.wr(8'h08, rows[i].setup);
      done_pulse;
      check({int_oe_n, scl_oe_n}, {!rows[i].ei, !rows[i].es});
      // SCL held low by the device would block the bus
      if (!rows[i].es) begin
        i_bus_ctrl_model.rd(8'h08, d);
        check(d, rows[i].setup & 8'hFD);
        check(int_oe_n, 1'b1);
      end
    end
    // Pulsed mode: low for 400 clocks, no bus access needed
    rst;
    i_bus_ctrl_model.wr(8'h08, 8'hA4);
    done_pulse;
    check(int_oe_n, 1'b0);
    repeat (398) @(posedge clk);
    #2 check(int_oe_n, 1'b0);
    @(posedge clk);
    #2 check(int_oe_n, 1'b1);
    // Four crossings needed when the count select is set
    rst;
    mode = sensor_mode_t'(5'h04);
    cr.axis[0] = 16'h1001;
    i_bus_ctrl_model.wr(8'h04, 8'h10);
    i_bus_ctrl_model.wr(8'h08, 8'h44);
    repeat (3) done_pulse;
    check(int_oe_n, 1'b1);
    done_pulse;
    check(int_oe_n, 1'b0);
    // Bus-aware route: event during a transfer waits for the stop
    rst;
    i_bus_ctrl_model.wr(8'h08, 8'h88);
    fork
      i_bus_ctrl_model.wr(8'h04, 8'h00);
      begin
        repeat (200) @(posedge clk);
        done_pulse;
        check(int_oe_n, 1'b1);
      end
    join
    repeat (4) @(posedge clk);
    #2 check(int_oe_n, 1'b0);
    // Pin edges wake and trigger unless masked
    rst;
    mode = sensor_mode_t'(5'h01);
    i_bus_ctrl_model.wr(8'h07, 8'h01);
    check(temp_channel_enable, 1'b1);
    wakes = 0;
    trigs = 0;
    pin_pulse;
    check({wakes[7:0], trigs[7:0]}, 16'h0101);
    i_bus_ctrl_model.wr(8'h08, 8'h01);
    pin_pulse;
    check({wakes[7:0], trigs[7:0]}, 16'h0101);
    i_bus_ctrl_model.wr(8'h07, 8'h00);
    check(temp_channel_enable, 1'b0);
    check(i_bus_ctrl_model.all_ack, 1'b1);
    tally_and_finish;
  end
endmodule
`default_nettype wire
